//--- design/caod_core.sv
// Purpose: Operand addressing and arithmetic execution of an 8-bit core
// Assumes: One 10 MHz clock, synchronous active-low reset, code_data
//          valid from the cycle after code_addr_reg changes
// Notes:   RAM is not cleared by reset; load it through the load port
`timescale 1ns/100ps
`default_nettype none
module caod_core #(
    parameter int RAM_BYTES = 256
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [7:0]  instr_op,
    input  wire logic [7:0]  instr_arg,
    output logic             ready_reg,
    output logic             done_reg,
    output logic [1:0]       len_reg,
    output logic             illegal_reg,
    // Direct-space load and observation
    input  wire logic        ld_valid,
    input  wire logic [7:0]  ld_addr,
    input  wire logic [7:0]  ld_data,
    input  wire logic [7:0]  peek_addr,
    output logic [7:0]       peek_data_reg,
    input  wire logic [7:0]  bit_addr,
    output logic             bit_val_reg,
    // Program memory read
    output logic [15:0]      code_addr_reg,
    input  wire logic [7:0]  code_data,
    // Architectural state
    output logic [7:0]       acc_reg,
    output logic [7:0]       b_reg,
    output logic [7:0]       psw_reg,
    output logic [15:0]      wide_data_pointer_reg
);
    // Refuse RAM sizes that 8-bit addressing cannot serve
    if (RAM_BYTES != 256) begin : g_size_chk
        $error("RAM_BYTES must be 256");
    end

    caod_pkg::caod_state_t state_reg;
    caod_pkg::caod_dcd_t   dcd_reg;
    caod_pkg::caod_dcd_t   c_dcd;
    logic [2:0]  rem_reg;
    logic [7:0]  opc_reg;
    logic [7:0]  arg_reg;
    logic [7:0]  ram [RAM_BYTES];
    logic        run;
    logic        take;
    logic        ld_take;
    logic        commit;
    logic [7:0]  c_opc;
    logic [7:0]  c_arg;
    logic [1:0]  bank;
    logic [7:0]  src_addr;
    logic [7:0]  src_val;
    logic [7:0]  acc_next;
    logic [7:0]  b_next;
    logic [7:0]  psw_next;
    logic [15:0] wide_data_pointer_next;
    logic        ram_we;
    logic [7:0]  ram_wa;
    logic [7:0]  ram_wd;
    logic        dwr;
    logic [7:0]  dwa;
    logic [7:0]  dwd;
    logic        cin;
    logic [8:0]  sum9;
    logic [4:0]  nib5;
    logic [7:0]  step;
    logic [15:0] prod;
    logic [8:0]  bcd9;
    logic        bcd_c;
    logic [7:0]  bit_byte;
    logic [7:0]  bit_src;
    logic [7:0]  peek_val;

    // Special register read by address, zero when unmapped
    function automatic logic [7:0] spr_rd(input logic [7:0] a, input logic [7:0] ac,
        input logic [7:0] bv, input logic [7:0] ps, input logic [15:0] dp);
        case (a)
            caod_pkg::ADR_ACC: spr_rd = ac;
            caod_pkg::ADR_AUX: spr_rd = bv;
            caod_pkg::ADR_PSW: spr_rd = ps;
            caod_pkg::ADR_PLO: spr_rd = dp[7:0];
            caod_pkg::ADR_PHI: spr_rd = dp[15:8];
            default:           spr_rd = 8'h00;
        endcase
    endfunction

    // Opcode to operation, source mode, length and cycle count
    function automatic caod_pkg::caod_dcd_t dcd_fn(input logic [7:0] opc);
        caod_pkg::caod_dcd_t d;
        logic                incdn;
        incdn = (opc[7:4] == caod_pkg::GRP_INC) || (opc[7:4] == caod_pkg::GRP_STEP_DN);
        d.op  = caod_pkg::OP_NONE;
        d.src = caod_pkg::SRC_NONE;
        d.len = caod_pkg::LEN_ONE;
        d.cyc = caod_pkg::CYC_BAD;
        if (opc[3])
            d.src = caod_pkg::SRC_REG;
        else if (opc[3:0] == caod_pkg::LO_IMM)
            d.src = incdn ? caod_pkg::SRC_ACC : caod_pkg::SRC_IMM;
        else if (opc[3:0] == caod_pkg::LO_DIR)
            d.src = caod_pkg::SRC_DIR;
        else if (opc[3:1] == caod_pkg::LO_IND)
            d.src = caod_pkg::SRC_IND;
        case (opc[7:4])
            caod_pkg::GRP_INC:     d.op = caod_pkg::OP_INC;
            caod_pkg::GRP_STEP_DN: d.op = caod_pkg::OP_STEP_DN;
            caod_pkg::GRP_ADD:     d.op = caod_pkg::OP_ADD;
            caod_pkg::GRP_ADD_CY:  d.op = caod_pkg::OP_ADD_CY;
            caod_pkg::GRP_SUB_BW:  d.op = caod_pkg::OP_SUB_BW;
            default:               d.op = caod_pkg::OP_NONE;
        endcase
        case (d.src)
            caod_pkg::SRC_REG: d.cyc = incdn ? caod_pkg::CYC_INC_REG : caod_pkg::CYC_ARI_REG;
            caod_pkg::SRC_DIR:
            begin
                d.len = caod_pkg::LEN_TWO;
                d.cyc = incdn ? caod_pkg::CYC_INC_DIR : caod_pkg::CYC_ARI_DIR;
            end
            caod_pkg::SRC_IND: d.cyc = incdn ? caod_pkg::CYC_INC_IND : caod_pkg::CYC_ARI_IND;
            caod_pkg::SRC_IMM:
            begin
                d.len = caod_pkg::LEN_TWO;
                d.cyc = caod_pkg::CYC_ARI_IMM;
            end
            caod_pkg::SRC_ACC: d.cyc = caod_pkg::CYC_INC_ACC;
            default:           d.op = caod_pkg::OP_NONE;
        endcase
        case (opc)
            caod_pkg::CODE_PTR_INC:
            begin
                d.op  = caod_pkg::OP_PTR_INC;
                d.cyc = caod_pkg::CYC_PTR_INC;
            end
            caod_pkg::CODE_PROD:
            begin
                d.op  = caod_pkg::OP_PROD;
                d.cyc = caod_pkg::CYC_PROD;
            end
            caod_pkg::CODE_QUOT:
            begin
                d.op  = caod_pkg::OP_QUOT;
                d.cyc = caod_pkg::CYC_QUOT;
            end
            caod_pkg::CODE_BCD:
            begin
                d.op  = caod_pkg::OP_BCD;
                d.cyc = caod_pkg::CYC_BCD;
            end
            caod_pkg::CODE_CODE_RD:
            begin
                d.op  = caod_pkg::OP_CODE_RD;
                d.cyc = caod_pkg::CYC_CODE_RD;
            end
            default: d.op = d.op;
        endcase
        if ((opc == caod_pkg::CODE_PTR_INC) || (opc == caod_pkg::CODE_PROD) ||
            (opc == caod_pkg::CODE_QUOT) || (opc == caod_pkg::CODE_BCD) ||
            (opc == caod_pkg::CODE_CODE_RD) || (d.op == caod_pkg::OP_NONE))
        begin
            d.src = caod_pkg::SRC_NONE;
            d.len = caod_pkg::LEN_ONE;
        end
        if (d.op == caod_pkg::OP_NONE)
            d.cyc = caod_pkg::CYC_BAD;
        return d;
    endfunction

    // Issue, current instruction and commit point
    assign run     = (state_reg == caod_pkg::ST_RUN);
    assign take    = instr_valid && ready_reg;
    assign ld_take = ld_valid && ready_reg && !instr_valid;
    assign c_opc   = run ? opc_reg : instr_op;
    assign c_arg   = run ? arg_reg : instr_arg;
    assign c_dcd   = run ? dcd_reg : dcd_fn(instr_op);
    assign commit  = (take && (c_dcd.cyc == caod_pkg::CYC_ONE)) ||
                     (run && (rem_reg == caod_pkg::CYC_ONE));
    assign bank    = psw_reg[caod_pkg::PSW_RS1:caod_pkg::PSW_RS0];

    // Operand address and value for the selected mode
    always_comb
    begin
        src_addr = c_arg;
        src_val  = 8'h00;
        case (c_dcd.src)
            caod_pkg::SRC_ACC: src_val = acc_reg;
            caod_pkg::SRC_REG:
            begin
                src_addr = {3'h0, bank, c_opc[2:0]};
                src_val  = ram[src_addr];
            end
            caod_pkg::SRC_IND:
            begin
                src_addr = ram[{3'h0, bank, 2'h0, c_opc[0]}];
                src_val  = ram[src_addr];
            end
            caod_pkg::SRC_DIR:
                src_val = c_arg[7] ? spr_rd(c_arg, acc_reg, b_reg, psw_reg, wide_data_pointer_reg)
                                   : ram[c_arg];
            caod_pkg::SRC_IMM: src_val = c_arg;
            default:           src_val = 8'h00;
        endcase
    end

    // Execute at commit, then apply loads and direct writes
    always_comb
    begin
        acc_next  = acc_reg;
        b_next    = b_reg;
        psw_next  = psw_reg;
        wide_data_pointer_next = wide_data_pointer_reg;
        ram_we    = 1'b0;
        ram_wa    = src_addr;
        ram_wd    = 8'h00;
        dwr       = 1'b0;
        dwa       = c_arg;
        dwd       = 8'h00;
        sum9      = 9'h000;
        nib5      = 5'h00;
        prod      = 16'h0000;
        bcd9      = 9'h000;
        bcd_c     = 1'b0;
        step      = (c_dcd.op == caod_pkg::OP_INC) ? src_val + 8'h01 : src_val - 8'h01;
        cin       = ((c_dcd.op == caod_pkg::OP_ADD_CY) || (c_dcd.op == caod_pkg::OP_SUB_BW))
                    && psw_reg[caod_pkg::PSW_CY];
        if (commit)
        begin
            case (c_dcd.op)
                caod_pkg::OP_ADD, caod_pkg::OP_ADD_CY:
                begin
                    sum9 = {1'b0, acc_reg} + {1'b0, src_val} + {8'h00, cin};
                    nib5 = {1'b0, acc_reg[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
                    acc_next = sum9[7:0];
                    psw_next[caod_pkg::PSW_CY] = sum9[8];
                    psw_next[caod_pkg::PSW_AC] = nib5[4];
                    psw_next[caod_pkg::PSW_OV] = (acc_reg[7] == src_val[7]) &&
                                                 (sum9[7] != acc_reg[7]);
                end
                caod_pkg::OP_SUB_BW:
                begin
                    sum9 = {1'b0, acc_reg} - {1'b0, src_val} - {8'h00, cin};
                    nib5 = {1'b0, acc_reg[3:0]} - {1'b0, src_val[3:0]} - {4'h0, cin};
                    acc_next = sum9[7:0];
                    psw_next[caod_pkg::PSW_CY] = sum9[8];
                    psw_next[caod_pkg::PSW_AC] = nib5[4];
                    psw_next[caod_pkg::PSW_OV] = (acc_reg[7] != src_val[7]) &&
                                                 (sum9[7] != acc_reg[7]);
                end
                caod_pkg::OP_INC, caod_pkg::OP_STEP_DN:
                begin
                    case (c_dcd.src)
                        caod_pkg::SRC_ACC: acc_next = step;
                        caod_pkg::SRC_DIR:
                        begin
                            dwr = 1'b1;
                            dwd = step;
                        end
                        default:
                        begin
                            ram_we = 1'b1;
                            ram_wd = step;
                        end
                    endcase
                end
                caod_pkg::OP_PTR_INC: wide_data_pointer_next = wide_data_pointer_reg + 16'h0001;
                caod_pkg::OP_PROD:
                begin
                    prod = {8'h00, acc_reg} * {8'h00, b_reg};
                    acc_next = prod[7:0];
                    b_next   = prod[15:8];
                    psw_next[caod_pkg::PSW_CY] = 1'b0;
                    psw_next[caod_pkg::PSW_OV] = |prod[15:8];
                end
                caod_pkg::OP_QUOT:
                begin
                    psw_next[caod_pkg::PSW_CY] = 1'b0;
                    psw_next[caod_pkg::PSW_OV] = (b_reg == 8'h00);
                    if (b_reg != 8'h00)
                    begin
                        acc_next = acc_reg / b_reg;
                        b_next   = acc_reg % b_reg;
                    end
                end
                caod_pkg::OP_BCD:
                begin
                    bcd9 = {1'b0, acc_reg};
                    if ((acc_reg[3:0] > caod_pkg::BCD_MAX) || psw_reg[caod_pkg::PSW_AC])
                        bcd9 = bcd9 + caod_pkg::BCD_LO;
                    bcd_c = bcd9[8];
                    if ((bcd9[7:4] > caod_pkg::BCD_MAX) || bcd_c || psw_reg[caod_pkg::PSW_CY])
                        bcd9 = {1'b0, bcd9[7:0]} + caod_pkg::BCD_HI;
                    acc_next = bcd9[7:0];
                    psw_next[caod_pkg::PSW_CY] = psw_reg[caod_pkg::PSW_CY] | bcd_c | bcd9[8];
                end
                caod_pkg::OP_CODE_RD: acc_next = code_data;
                default: acc_next = acc_reg;
            endcase
        end
        if (ld_take)
        begin
            dwr = 1'b1;
            dwa = ld_addr;
            dwd = ld_data;
        end
        if (dwr && !dwa[7])
        begin
            ram_we = 1'b1;
            ram_wa = dwa;
            ram_wd = dwd;
        end
        else if (dwr)
        begin
            case (dwa)
                caod_pkg::ADR_ACC: acc_next = dwd;
                caod_pkg::ADR_AUX: b_next = dwd;
                caod_pkg::ADR_PSW: psw_next = dwd;
                caod_pkg::ADR_PLO: wide_data_pointer_next[7:0] = dwd;
                caod_pkg::ADR_PHI: wide_data_pointer_next[15:8] = dwd;
                default: wide_data_pointer_next = wide_data_pointer_next;
            endcase
        end
        psw_next[caod_pkg::PSW_P] = ^acc_next;
    end

    // Sequencer: holds multi-cycle instructions until their count ends
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= caod_pkg::ST_IDLE;
            rem_reg   <= 3'h0;
            ready_reg <= 1'b0;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= commit;
            case (state_reg)
                caod_pkg::ST_IDLE:
                begin
                    ready_reg <= 1'b1;
                    if (take && (c_dcd.cyc != caod_pkg::CYC_ONE))
                    begin
                        state_reg <= caod_pkg::ST_RUN;
                        rem_reg   <= c_dcd.cyc - caod_pkg::CYC_ONE;
                        ready_reg <= 1'b0;
                    end
                end
                caod_pkg::ST_RUN:
                begin
                    if (rem_reg == caod_pkg::CYC_ONE)
                    begin
                        state_reg <= caod_pkg::ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                    else
                        rem_reg <= rem_reg - caod_pkg::CYC_ONE;
                end
                default: state_reg <= caod_pkg::ST_IDLE;
            endcase
        end
    end

    // Latch the accepted instruction and its length
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            opc_reg     <= 8'h00;
            arg_reg     <= 8'h00;
            dcd_reg     <= '0;
            len_reg     <= 2'h0;
            illegal_reg <= 1'b0;
        end
        else if (take)
        begin
            opc_reg     <= instr_op;
            arg_reg     <= instr_arg;
            dcd_reg     <= c_dcd;
            len_reg     <= c_dcd.len;
            illegal_reg <= (c_dcd.op == caod_pkg::OP_NONE);
        end
    end

    // Indexed program address, presented from issue onward
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            code_addr_reg <= caod_pkg::RST_PTR;
        else if (take && (c_dcd.op == caod_pkg::OP_CODE_RD))
            code_addr_reg <= wide_data_pointer_reg + {8'h00, acc_reg};
    end

    // Architectural registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_reg  <= caod_pkg::RST_ACC;
            b_reg    <= caod_pkg::RST_AUX;
            psw_reg  <= caod_pkg::RST_PSW;
            wide_data_pointer_reg <= caod_pkg::RST_PTR;
        end
        else
        begin
            acc_reg  <= acc_next;
            b_reg    <= b_next;
            psw_reg  <= psw_next;
            wide_data_pointer_reg <= wide_data_pointer_next;
        end
    end

    // Internal RAM, holding the banked working registers too
    always_ff @(posedge clk)
    begin
        if (ram_we)
            ram[ram_wa] <= ram_wd;
    end

    // Bit and byte observation taps
    always_comb
    begin
        bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0}
                               : caod_pkg::BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
        bit_src  = bit_byte[7] ? spr_rd(bit_byte, acc_reg, b_reg, psw_reg, wide_data_pointer_reg)
                               : ram[bit_byte];
        peek_val = peek_addr[7] ? spr_rd(peek_addr, acc_reg, b_reg, psw_reg, wide_data_pointer_reg)
                                : ram[peek_addr];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bit_val_reg   <= 1'b0;
            peek_data_reg <= 8'h00;
        end
        else
        begin
            bit_val_reg   <= bit_src[bit_addr[2:0]];
            peek_data_reg <= peek_val;
        end
    end
endmodule // caod_core
`default_nettype wire

//--- pkg/caod_pkg.sv
// Purpose: Shared constants and types for the operand and arithmetic unit
// Assumes: 8-bit data, 16-bit wide data pointer, 256-byte internal RAM
// Notes:   Opcode values follow the classic 8-bit instruction encoding
package caod_pkg;
    // Special function register addresses
    localparam logic [7:0] ADR_ACC = 8'hE0;
    localparam logic [7:0] ADR_AUX = 8'hF0;
    localparam logic [7:0] ADR_PSW = 8'hD0;
    localparam logic [7:0] ADR_PLO = 8'h82;
    localparam logic [7:0] ADR_PHI = 8'h83;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    // Status word bit positions
    localparam int PSW_CY  = 7;
    localparam int PSW_AC  = 6;
    localparam int PSW_RS1 = 4;
    localparam int PSW_RS0 = 3;
    localparam int PSW_OV  = 2;
    localparam int PSW_P   = 0;
    // Reset values
    localparam logic [7:0]  RST_ACC = 8'h00;
    localparam logic [7:0]  RST_AUX = 8'h00;
    localparam logic [7:0]  RST_PSW = 8'h00;
    localparam logic [15:0] RST_PTR = 16'h0000;
    // Opcode groups, low-nibble source fields and full opcodes
    localparam logic [3:0] GRP_INC     = 4'h0;
    localparam logic [3:0] GRP_STEP_DN = 4'h1;
    localparam logic [3:0] GRP_ADD     = 4'h2;
    localparam logic [3:0] GRP_ADD_CY  = 4'h3;
    localparam logic [3:0] GRP_SUB_BW  = 4'h9;
    localparam logic [3:0] LO_IMM      = 4'h4;
    localparam logic [3:0] LO_DIR      = 4'h5;
    localparam logic [2:0] LO_IND      = 3'h3;
    localparam logic [7:0] CODE_PTR_INC = 8'hA3;
    localparam logic [7:0] CODE_PROD    = 8'hA4;
    localparam logic [7:0] CODE_QUOT    = 8'h84;
    localparam logic [7:0] CODE_BCD     = 8'hD4;
    localparam logic [7:0] CODE_CODE_RD = 8'h93;
    // Instruction lengths in bytes
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    // Cycle counts
    localparam logic [2:0] CYC_ONE     = 3'h1;
    localparam logic [2:0] CYC_ARI_REG = 3'h1;
    localparam logic [2:0] CYC_ARI_DIR = 3'h2;
    localparam logic [2:0] CYC_ARI_IND = 3'h2;
    localparam logic [2:0] CYC_ARI_IMM = 3'h2;
    localparam logic [2:0] CYC_INC_ACC = 3'h1;
    localparam logic [2:0] CYC_INC_REG = 3'h2;
    localparam logic [2:0] CYC_INC_DIR = 3'h3;
    localparam logic [2:0] CYC_INC_IND = 3'h3;
    localparam logic [2:0] CYC_PTR_INC = 3'h1;
    localparam logic [2:0] CYC_PROD    = 3'h2;
    localparam logic [2:0] CYC_QUOT    = 3'h6;
    localparam logic [2:0] CYC_BCD     = 3'h3;
    localparam logic [2:0] CYC_CODE_RD = 3'h5;
    localparam logic [2:0] CYC_BAD     = 3'h1;
    // Decimal fix-up constants
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO  = 9'h006;
    localparam logic [8:0] BCD_HI  = 9'h060;
    // Operations, source modes, sequencer states, decode record
    typedef enum logic [3:0] {
        OP_NONE, OP_ADD, OP_ADD_CY, OP_SUB_BW, OP_INC, OP_STEP_DN,
        OP_PTR_INC, OP_PROD, OP_QUOT, OP_BCD, OP_CODE_RD
    } caod_op_t;
    typedef enum logic [2:0] {
        SRC_NONE, SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM
    } caod_src_t;
    typedef enum logic {ST_IDLE, ST_RUN} caod_state_t;
    typedef struct packed {
        caod_op_t   op;
        caod_src_t  src;
        logic [1:0] len;
        logic [2:0] cyc;
    } caod_dcd_t;
endpackage

//--- test/caod_core_props.sv
// Purpose: Timing and result properties of the operand and arithmetic unit
// Assumes: Single clock, synchronous active-low reset
// Notes:   Bound to the top module from the testbench file
`timescale 1ns/100ps
`default_nettype none
module caod_core_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Issue and state
    input wire logic        instr_valid,
    input wire logic [7:0]  instr_op,
    input wire logic        ready_reg,
    input wire logic        done_reg,
    input wire logic [1:0]  len_reg,
    input wire logic [15:0] code_addr_reg,
    input wire logic [7:0]  acc_reg,
    input wire logic [15:0] wide_data_pointer_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // An instruction is taken when offered while ready
    wire take = instr_valid && ready_reg;
    wire arith = instr_op[7:4] == 4'h2 || instr_op[7:4] == 4'h3 || instr_op[7:4] == 4'h9;
    chk_reg_src_one: assert property (take && arith && instr_op[3]
        |=> done_reg && ready_reg)
        else $error("register-source arithmetic not done in one cycle");
    chk_two_byte_len: assert property (take && arith && instr_op[3:1] == 3'h2
        |=> len_reg == 2'h2) else $error("immediate or direct arithmetic length not two");
    chk_quot_six: assert property (take && instr_op == caod_pkg::CODE_QUOT
        |=> (!ready_reg && !done_reg)[*5] ##1 (ready_reg && done_reg))
        else $error("divide not six cycles");
    chk_prod_two: assert property (take && instr_op == caod_pkg::CODE_PROD
        |=> !ready_reg ##1 (done_reg && ready_reg)) else $error("multiply not two cycles");
    chk_inc_dir_three: assert property (take && (instr_op == 8'h05 || instr_op == 8'h15)
        |=> (!ready_reg)[*2] ##1 done_reg) else $error("direct step not three cycles");
    chk_bcd_three: assert property (take && instr_op == caod_pkg::CODE_BCD
        |-> ##3 done_reg) else $error("decimal fix-up not three cycles");
    chk_code_addr_sum: assert property (take && instr_op == caod_pkg::CODE_CODE_RD
        |=> code_addr_reg == $past(wide_data_pointer_reg) + {8'h00, $past(acc_reg)})
        else $error("code address wrong");
    chk_ptr_step: assert property (take && instr_op == caod_pkg::CODE_PTR_INC
        |=> wide_data_pointer_reg == $past(wide_data_pointer_reg) + 16'h0001) else $error("pointer step wrong");
    chk_acc_step: assert property (take && instr_op == 8'h04
        |=> acc_reg == $past(acc_reg) + 8'h01) else $error("accumulator step wrong");
endmodule // caod_core_props
`default_nettype wire

//--- test/caod_core_tb.sv
// Purpose: Self-checking bench for the operand and arithmetic unit
// Assumes: 10 MHz clock, reset held six cycles
// Notes:   One table walks every addressing mode and arithmetic operation
`timescale 1ns/100ps
`default_nettype none
module caod_core_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        instr_valid = 1'b0, ld_valid = 1'b0;
    logic [7:0]  instr_op = 8'h00, instr_arg = 8'h00, ld_addr = 8'h00, ld_data = 8'h00;
    logic [7:0]  peek_addr = 8'h40;
    logic [7:0]  bit_addr = 8'h00, peek_data_reg, acc_reg, b_reg, psw_reg, code_data;
    logic        ready_reg, done_reg, illegal_reg, bit_val_reg;
    logic [1:0]  len_reg;
    logic [15:0] code_addr_reg, wide_data_pointer_reg;
    int          failures = 0, samples_checked = 0;
    // Entries: opcode, second byte, expected acc, {carry,0,length}, cycles
    logic [31:0] tbl [21] = '{32'h247F7F22, 32'h2800AF11, 32'h2700D112, 32'h2540D622,
        32'h343006A2, 32'h38003711, 32'h9440F7A2, 32'h9540F122, 32'h9600E012, 32'h9900AF11,
        32'h0400B011, 32'h1400AF11, 32'h0800AF12, 32'h0540AF23, 32'h1600AF13, 32'hA300AF11,
        32'hA4000D12, 32'h84000616, 32'hD4000C13, 32'h93005715, 32'hA5005711};
    always #50 clk = ~clk;
    // Unit under test and its program memory
    caod_core DUT (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_arg(instr_arg), .ready_reg(ready_reg), .done_reg(done_reg), .len_reg(len_reg),
        .illegal_reg(illegal_reg), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_data(ld_data),
        .peek_addr(peek_addr), .peek_data_reg(peek_data_reg), .bit_addr(bit_addr),
        .bit_val_reg(bit_val_reg), .code_addr_reg(code_addr_reg), .code_data(code_data),
        .acc_reg(acc_reg), .b_reg(b_reg), .psw_reg(psw_reg), .wide_data_pointer_reg(wide_data_pointer_reg));
    caod_prog_mem u_mem (.code_addr(code_addr_reg), .code_data(code_data));
    // Comparisons and verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input int got, input int exp);
        samples_checked++;
        if (got != exp)
        begin
            failures++;
            $display("ERROR at %0t: took %0d cycles expected %0d", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Bus cycles
    task automatic ld(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        ld_valid <= 1'b1;
        ld_addr  <= a;
        ld_data  <= d;
        @(posedge clk);
        ld_valid <= 1'b0;
    endtask
    task automatic issue(input logic [7:0] op, input logic [7:0] arg, output int k);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_arg   <= arg;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        k = 1;
        while (done_reg !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    // Scenarios
    task automatic test_reset;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk({acc_reg, psw_reg}, 16'h0000);
        chk(wide_data_pointer_reg, 16'h0000);
        chk({15'h0000, ready_reg}, 16'h0001);
    endtask
    task automatic load_ram;
        ld(8'h00, 8'h30);
        ld(8'h01, 8'h31);
        ld(8'h30, 8'h11);
        ld(8'h31, 8'h22);
        ld(8'h40, 8'h05);
        ld(8'hF0, 8'h03);
        @(posedge clk);
        #1;
        chk({8'h00, peek_data_reg}, 16'h0005);
    endtask
    task automatic run_arith;
        int k;
        for (int i = 0; i < 21; i++)
        begin
            issue(tbl[i][31:24], tbl[i][23:16], k);
            chk_cyc(k, int'(tbl[i][3:0]));
            chk({8'h00, acc_reg}, {8'h00, tbl[i][15:8]});
            chk({14'h0000, len_reg}, {14'h0000, tbl[i][5:4]});
            chk({15'h0000, psw_reg[7]}, {15'h0000, tbl[i][7]});
        end
        chk({15'h0000, illegal_reg}, 16'h0001);
        chk({b_reg, psw_reg}, 16'h0141);
        chk(wide_data_pointer_reg, 16'h0001);
        chk({8'h00, peek_data_reg}, 16'h0006);
        @(posedge clk);
        peek_addr <= 8'h31;
        repeat (2) @(posedge clk);
        #1;
        chk({8'h00, peek_data_reg}, 16'h0021);
    endtask
    task automatic test_bit;
        ld(8'h2F, 8'h80);
        bit_addr <= 8'h7F;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, bit_val_reg}, 16'h0001);
        @(posedge clk);
        bit_addr <= 8'hE2;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, bit_val_reg}, 16'h0001);
    endtask
    // Bank one working register feeds a register-source add
    task automatic test_bank;
        int k;
        ld(8'hD0, 8'h08);
        ld(8'h08, 8'h04);
        issue(8'h28, 8'h00, k);
        chk_cyc(k, 1);
        chk({8'h00, acc_reg}, 16'h005B);
    endtask
    // Watchdog
    initial
    begin
        #200000;
        failures++;
        print_verdict;
    end
    // Main sequence
    initial
    begin
        test_reset;
        load_ram;
        run_arith;
        test_bit;
        test_bank;
        print_verdict;
    end
endmodule // caod_core_tb
bind caod_core caod_core_props u_props (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .ready_reg(ready_reg), .done_reg(done_reg), .len_reg(len_reg),
    .code_addr_reg(code_addr_reg), .acc_reg(acc_reg), .wide_data_pointer_reg(wide_data_pointer_reg));
`default_nettype wire

//--- test/caod_prog_mem.sv
// Purpose: Program memory model answering indexed code reads
// Assumes: Address is held stable by the core until its commit edge
// Notes:   Content is a fixed pattern of both address halves
`timescale 1ns/100ps
`default_nettype none
module caod_prog_mem (
    // Program fetch
    input  wire logic [15:0] code_addr,
    output logic      [7:0]  code_data
);
    // Byte pattern derived from the whole address
    assign code_data = code_addr[7:0] ^ code_addr[15:8] ^ 8'h5A;
endmodule // caod_prog_mem
`default_nettype wire
